// ### include/dbi_deskew_pkg.sv
package dbi_deskew_pkg;
   // ----------------------------------------
   // Geometry
   // ----------------------------------------
   localparam int LANES      = 8;
   localparam int LANE_W     = 6;
   localparam int DATA_W     = 64;
   localparam int LANE_DW    = 8;
   localparam int STATUS_W   = 41;
   localparam int RANKS      = 1;
   localparam int ERR_BIT_W  = 8;
   localparam int ERR_NIB_W  = 8;
   localparam int ERR_CODE_W = 4;
   // ----------------------------------------
   // Status and error encodings
   // ----------------------------------------
   localparam int STAT_DBI_DESKEW_BIT = 8;
   localparam int STAT_DBI_DONE_BIT   = 9;
   localparam logic [ERR_CODE_W-1:0] ERR_NONE     = 4'h0;
   localparam logic [ERR_CODE_W-1:0] ERR_MISMATCH = 4'h1;
   localparam logic [ERR_CODE_W-1:0] ERR_TIMEOUT  = 4'h2;
   // ----------------------------------------
   // Command pin levels (cs_n, ras_n, cas_n, we_n, act_n)
   // ----------------------------------------
   localparam logic [4:0] CMD_WRITE = 5'h17;
   localparam logic [4:0] CMD_READ  = 5'h15;
   localparam logic [4:0] CMD_IDLE  = 5'h1f;
   // ----------------------------------------
   // Counts
   // ----------------------------------------
   localparam logic [7:0] RD_BURSTS_HW  = 8'h40;
   localparam logic [7:0] RD_BURSTS_SIM = 8'h05;
   localparam int RD_TIMEOUT_NS = 2000;
   localparam int CLK_NS        = 20;
   localparam logic [7:0] RD_TIMEOUT_CYC = 8'(RD_TIMEOUT_NS / CLK_NS);
   localparam logic [7:0] WR_GAP_CYC     = 8'h04;
   localparam logic [7:0] LOOP_GAP_CYC   = 8'h08;
endpackage : dbi_deskew_pkg

// ### design/lane_compare.sv
`timescale 1ns/100ps
module lane_compare
   import dbi_deskew_pkg::*;
(
   input  wire logic [DATA_W-1:0] rd_data_i,
   input  wire logic [DATA_W-1:0] exp_data_i,
   input  wire logic [LANE_W-1:0] lane_i,
   output logic      [DATA_W-1:0] cmp_o,
   output logic                   lane_ok_o,
   output logic [ERR_BIT_W-1:0]   first_bad_o
);
   logic [LANE_DW-1:0] lane_diff;
   assign cmp_o = rd_data_i ^ exp_data_i;
   assign lane_diff = cmp_o[lane_i[2:0]*LANE_DW +: LANE_DW];
   assign lane_ok_o = (lane_diff == '0);
   always_comb begin
      first_bad_o = '0;
      for (int i = LANE_DW - 1; i >= 0; i--) begin
         if (lane_diff[i]) begin
            first_bad_o = ERR_BIT_W'({lane_i[2:0], 3'(i)});
         end
      end
   end
endmodule : lane_compare

// ### design/dbi_deskew_stage.sv
`timescale 1ns/100ps
module dbi_deskew_stage
   import dbi_deskew_pkg::*;
#(
   parameter bit SIM_MODE = 1'b0
)(
   input  wire logic                   clk_i,
   input  wire logic                   rst_n_i,
   input  wire logic                   start_i,
   input  wire logic                   rd_valid_i,
   input  wire logic [DATA_W-1:0]      rd_data_i,
   output logic                        cs_n_o,
   output logic                        ras_n_o,
   output logic                        cas_n_o,
   output logic                        we_n_o,
   output logic                        act_n_o,
   output logic                        dbi_n_o,
   output logic [DATA_W-1:0]           wr_data_o,
   output logic                        wr_en_o,
   output logic [STATUS_W-1:0]         cal_status_o [RANKS],
   output logic                        done_o,
   output logic                        cal_error_o,
   output logic [ERR_BIT_W-1:0]        cal_error_bit_o,
   output logic [ERR_NIB_W-1:0]        cal_error_nibble_o,
   output logic [ERR_CODE_W-1:0]       cal_error_code_o,
   output logic [DATA_W-1:0]           dbg_rd_data_o,
   output logic [DATA_W-1:0]           dbg_rd_data_cmp_o,
   output logic                        dbg_rd_valid_o,
   output logic [LANE_W-1:0]           dbg_cmp_byte_o,
   output logic [7:0]                  dbg_rd_cnt_o
);
   // ----------------------------------------
   // Reset release
   // ----------------------------------------
   logic rst_sync1;
   logic rst_n;
   always_ff @(posedge clk_i or negedge rst_n_i) begin
      if (!rst_n_i) begin
         rst_sync1 <= 1'b0;
         rst_n     <= 1'b0;
      end else begin
         rst_sync1 <= 1'b1;
         rst_n     <= rst_sync1;
      end
   end

   // ----------------------------------------
   // State machine
   // ----------------------------------------
   typedef enum logic [2:0] {S_IDLE, S_WRITE, S_WGAP, S_READ, S_WAIT, S_NEXT, S_DONE, S_FAIL} state_t;
   state_t state;
   state_t next_state;
   logic [LANE_W-1:0] lane;
   logic [7:0] rd_left;
   logic [7:0] timer;
   logic       pattern;
   logic [DATA_W-1:0] exp_data;
   logic [DATA_W-1:0] cmp;
   logic              lane_ok;
   logic [ERR_BIT_W-1:0] bad_bit;
   logic [7:0] bursts;
   logic       last_lane;
   logic       timeout;
   logic       mismatch;
   logic       issue_rd;

   assign bursts    = SIM_MODE ? RD_BURSTS_SIM : RD_BURSTS_HW;
   assign exp_data  = {DATA_W{pattern}};
   assign last_lane = (lane == LANE_W'(LANES - 1));
   assign timeout   = (state == S_WAIT) && (timer == '0) && !rd_valid_i;
   assign mismatch  = (state == S_WAIT) && rd_valid_i && !lane_ok;
   assign issue_rd  = (state == S_READ) || ((state == S_FAIL) && (timer == '0));

   lane_compare u_cmp (
      .rd_data_i   (rd_data_i),
      .exp_data_i  (exp_data),
      .lane_i      (lane),
      .cmp_o       (cmp),
      .lane_ok_o   (lane_ok),
      .first_bad_o (bad_bit)
   );

   always_comb begin
      next_state = state;
      case (state)
         S_IDLE:  if (start_i) next_state = S_WRITE;
         S_WRITE: next_state = S_WGAP;
         S_WGAP:  if (timer == '0) next_state = S_READ;
         S_READ:  next_state = S_WAIT;
         S_WAIT: begin
            if (mismatch || timeout) begin
               next_state = S_FAIL;
            end else if (rd_valid_i) begin
               next_state = (rd_left == 8'h01) ? S_NEXT : S_READ;
            end
         end
         // Next lane only after this one completes.
         S_NEXT: begin
            if (!pattern) begin
               next_state = S_WRITE;
            end else begin
               next_state = last_lane ? S_DONE : S_WRITE;
            end
         end
         S_DONE:  next_state = S_DONE;
         S_FAIL:  next_state = S_FAIL;
         default: next_state = S_IDLE;
      endcase
   end

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         state   <= S_IDLE;
         lane    <= '0;
         rd_left <= '0;
         timer   <= '0;
         pattern <= 1'b0;
      end else begin
         state <= next_state;
         if (state == S_WRITE) begin
            timer   <= WR_GAP_CYC;
            rd_left <= bursts;
         end else if (state == S_READ) begin
            timer <= RD_TIMEOUT_CYC;
         end else if (timer != '0) begin
            timer <= timer - 8'h01;
         end else if (state == S_FAIL) begin
            timer <= LOOP_GAP_CYC;
         end
         if (state == S_WAIT && rd_valid_i) begin
            rd_left <= rd_left - 8'h01;
         end
         if (state == S_NEXT) begin
            pattern <= ~pattern;
            if (pattern && !last_lane) begin
               lane <= lane + LANE_W'(1);
            end
         end
      end
   end

   // ----------------------------------------
   // Memory command pins
   // ----------------------------------------
   logic [4:0] cmd;
   // Write and read differ only in we_n.
   assign cmd = (state == S_WRITE) ? CMD_WRITE : (issue_rd ? CMD_READ : CMD_IDLE);

   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         {cs_n_o, ras_n_o, cas_n_o, we_n_o, act_n_o} <= CMD_IDLE;
         dbi_n_o   <= 1'b1;
         wr_data_o <= '0;
         wr_en_o   <= 1'b0;
      end else begin
         {cs_n_o, ras_n_o, cas_n_o, we_n_o, act_n_o} <= cmd;
         dbi_n_o   <= 1'b1;
         wr_data_o <= exp_data;
         wr_en_o   <= (state == S_WRITE);
      end
   end

   // ----------------------------------------
   // Status, error and debug outputs
   // ----------------------------------------
   always_ff @(posedge clk_i or negedge rst_n) begin
      if (!rst_n) begin
         cal_status_o       <= '{default: '0};
         done_o             <= 1'b0;
         cal_error_o        <= 1'b0;
         cal_error_bit_o    <= '0;
         cal_error_nibble_o <= '0;
         cal_error_code_o   <= ERR_NONE;
         dbg_rd_data_o      <= '0;
         dbg_rd_data_cmp_o  <= '0;
         dbg_rd_valid_o     <= 1'b0;
         dbg_cmp_byte_o     <= '0;
         dbg_rd_cnt_o       <= '0;
      end else begin
         if (state == S_IDLE && start_i) begin
            cal_status_o[0][STAT_DBI_DESKEW_BIT] <= 1'b1;
         end
         if (next_state == S_DONE && state != S_DONE) begin
            cal_status_o[0][STAT_DBI_DONE_BIT] <= 1'b1;
            done_o <= 1'b1;
         end
         if ((mismatch || timeout) && !cal_error_o) begin
            cal_error_o        <= 1'b1;
            cal_error_bit_o    <= mismatch ? bad_bit : '0;
            cal_error_nibble_o <= ERR_NIB_W'({lane, 1'b0} | ((bad_bit[2]) ? 1 : 0));
            cal_error_code_o   <= mismatch ? ERR_MISMATCH : ERR_TIMEOUT;
         end
         dbg_rd_data_o     <= rd_data_i;
         dbg_rd_data_cmp_o <= cmp;
         dbg_rd_valid_o    <= rd_valid_i;
         dbg_cmp_byte_o    <= lane;
         dbg_rd_cnt_o      <= rd_left;
      end
   end

   // ----------------------------------------
   // Checks
   // ----------------------------------------
   a_lane_order: assert property (@(posedge clk_i) disable iff (!rst_n)
      (lane != $past(lane)) |-> (lane == $past(lane) + LANE_W'(1)) && ($past(state) == S_NEXT))
      else $error("Lane advanced out of order.");
   a_read_after_write: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state == S_WRITE) |=> (state == S_WGAP) ##[1:8] (state == S_READ))
      else $error("Read did not follow write.");
   a_cmd_levels: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state == S_WRITE) |=> (we_n_o && !ras_n_o && cas_n_o && cs_n_o && act_n_o))
      else $error("Write command levels wrong.");
   a_read_levels: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state == S_FAIL && timer == '0) |=> (!we_n_o && !ras_n_o) ##1 (state == S_FAIL))
      else $error("Failure loop did not read.");
   a_dbi_off: assert property (@(posedge clk_i) disable iff (!rst_n)
      wr_en_o |-> dbi_n_o)
      else $error("DBI asserted in write.");
   a_dbg_align: assert property (@(posedge clk_i) disable iff (!rst_n)
      rd_valid_i |=> dbg_rd_valid_o && (dbg_rd_data_o == $past(rd_data_i)))
      else $error("Debug data misaligned.");
   a_stage_start: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state == S_IDLE && start_i) |=> $rose(cal_status_o[0][STAT_DBI_DESKEW_BIT]))
      else $error("Stage status bit did not rise.");
   a_error_hold: assert property (@(posedge clk_i) disable iff (!rst_n)
      cal_error_o |=> cal_error_o && $stable(cal_error_code_o) && $stable(cal_error_bit_o))
      else $error("Error details changed.");
   a_fail_terminal: assert property (@(posedge clk_i) disable iff (!rst_n)
      (state == S_FAIL) |=> (state == S_FAIL) && !wr_en_o && !done_o)
      else $error("Calibration went on after failure.");
   a_dbg_lane: assert property (@(posedge clk_i) disable iff (!rst_n)
      dbg_cmp_byte_o == $past(lane))
      else $error("Debug lane index wrong.");
   a_done_status: assert property (@(posedge clk_i) disable iff (!rst_n)
      done_o |-> cal_status_o[0][STAT_DBI_DESKEW_BIT])
      else $error("Stage bit lost at completion.");
   a_error_rise: assert property (@(posedge clk_i) disable iff (!rst_n)
      mismatch |=> cal_error_o && (state == S_FAIL))
      else $error("Mismatch did not raise error.");
endmodule : dbi_deskew_stage

// ### verification/dram_model.sv
`timescale 1ns/100ps
module dram_model
   import dbi_deskew_pkg::*;
(
   input  wire logic              clk_i,
   input  wire logic [4:0]        cmd_i,
   input  wire logic              wr_en_i,
   input  wire logic [DATA_W-1:0] wr_data_i,
   input  wire logic [3:0]        lat_i,
   input  wire logic              mute_i,
   input  wire logic [DATA_W-1:0] flip_i,
   output logic                   rd_valid_o,
   output logic [DATA_W-1:0]      rd_data_o
);
   logic [DATA_W-1:0] store = '0;
   int                cnt   = 0;
   initial rd_valid_o = 1'b0;
   initial rd_data_o = '0;
   always @(posedge clk_i) begin
      if (cnt == 1) begin
         rd_valid_o <= #1 1'b1;
         rd_data_o  <= #1 store ^ flip_i;
      end else begin
         rd_valid_o <= #1 1'b0;
         rd_data_o  <= #1 ~rd_data_o;
      end
      if (wr_en_i) store <= wr_data_i;
      if (cmd_i !== 5'h1f && !wr_en_i && !mute_i) cnt <= int'(lat_i) + 1;
      else if (cnt > 0) cnt <= cnt - 1;
   end
endmodule : dram_model

// ### verification/dbi_deskew_stage_tb.sv
`timescale 1ns/100ps
module dbi_deskew_stage_tb;
   import dbi_deskew_pkg::*;
   localparam int N = 5;
   logic clk_i = 1'b0, rst_n_i = 1'b0, start = 1'b0, mute = 1'b0, mon = 1'b0, pv = 1'b0;
   logic rd_valid, cs_n, ras_n, cas_n, we_n, act_n, dbi_n, wr_en, done, cal_error, dbg_valid;
   logic [DATA_W-1:0] rd_data, wr_data, dbg_data, dbg_cmp, pd, pat, flip = '0;
   logic [STATUS_W-1:0] cal_status [RANKS];
   logic [7:0] err_bit, err_nib, dbg_cnt;
   logic [3:0] err_code, lat = 4'h1;
   logic [LANE_W-1:0] dbg_byte;
   int errors = 0, comparisons = 0, wr_cnt, rd_cnt, rd_grp, lane, bitn, w0, r0, seed;
   wire [4:0] cmd = {cs_n, ras_n, cas_n, we_n, act_n};
   initial forever #10 clk_i = ~clk_i;
   dbi_deskew_stage #(.SIM_MODE(1'b1)) uut (.clk_i(clk_i), .rst_n_i(rst_n_i), .start_i(start),
      .rd_valid_i(rd_valid), .rd_data_i(rd_data), .cs_n_o(cs_n), .ras_n_o(ras_n), .cas_n_o(cas_n),
      .we_n_o(we_n), .act_n_o(act_n), .dbi_n_o(dbi_n), .wr_data_o(wr_data), .wr_en_o(wr_en),
      .cal_status_o(cal_status), .done_o(done), .cal_error_o(cal_error), .cal_error_bit_o(err_bit),
      .cal_error_nibble_o(err_nib), .cal_error_code_o(err_code), .dbg_rd_data_o(dbg_data),
      .dbg_rd_data_cmp_o(dbg_cmp), .dbg_rd_valid_o(dbg_valid), .dbg_cmp_byte_o(dbg_byte),
      .dbg_rd_cnt_o(dbg_cnt));
   dram_model dram (.clk_i(clk_i), .cmd_i(cmd), .wr_en_i(wr_en), .wr_data_i(wr_data), .lat_i(lat),
      .mute_i(mute), .flip_i(flip), .rd_valid_o(rd_valid), .rd_data_o(rd_data));
   // ----------------------------------------
   // Tasks
   // ----------------------------------------
   task check(input string name, input logic [63:0] seen, input logic [63:0] exp);
      comparisons++;
      if (seen !== exp) begin
         errors++;
         $display("[FAIL] %s expected %h seen %h", name, exp, seen);
      end
   endtask : check
   task stop_test;
      $display("comparisons %0d errors %0d", comparisons, errors);
      if (errors == 0 && comparisons > 0)
         $display("== PASSED ==");
      else
         $display("== FAILED ==");
      $finish;
   endtask : stop_test
   task do_reset;
      @(posedge clk_i);
      #1 rst_n_i = 1'b0;
      mon = 1'b0;
      lat = 4'($urandom_range(1, 3));
      repeat (6) @(posedge clk_i);
      #1 rst_n_i = 1'b1;
      wr_cnt = 0;
      rd_cnt = 0;
      rd_grp = 0;
      pv = 1'b0;
      repeat (4) @(posedge clk_i);
   endtask : do_reset
   task go;
      #1 start = 1'b1;
      mon = 1'b1;
      @(posedge clk_i);
      #1 start = 1'b0;
   endtask : go
   task wait_for(input bit on_err, input int lim);
      int i;
      for (i = 0; i < lim && (on_err ? cal_error : done) !== 1'b1; i++) @(posedge clk_i);
      if (i < lim) #1;
      else begin
         errors++;
         $display("[FAIL] wait expected 1 seen 0");
         stop_test;
      end
   endtask : wait_for
   // ----------------------------------------
   // Monitor and sequence
   // ----------------------------------------
   always @(posedge clk_i) if (mon) begin
      check("dbg_rd_valid", dbg_valid, pv);
      if (pv) check("dbg_rd_data", dbg_data, pd);
      if (pv) check("dbg_rd_data_cmp", dbg_cmp, pd ^ pat);
      pv <= rd_valid;
      pd <= rd_data;
      if (wr_en) begin
         check("write cmd", cmd, 5'h17);
         check("dbi_n", dbi_n, 1);
         check("write pattern", wr_data, {64{wr_cnt[0]}});
         if (wr_cnt > 0) check("reads per write", rd_grp, N);
         pat <= {64{wr_cnt[0]}};
         wr_cnt++;
         rd_grp = 0;
      end else if (cmd !== 5'h1f) begin
         check("read cmd", cmd, 5'h15);
         if (!cal_error) check("lane", dbg_byte, rd_cnt / (2 * N));
         if (!cal_error) check("reads left", dbg_cnt, N - rd_grp);
         rd_cnt++;
         rd_grp++;
      end
   end
   initial begin
      seed = $urandom(32);
      do_reset;
      check("idle cmd", cmd, 5'h1f);
      check("status", cal_status[0], 0);
      check("error", {cal_error, err_code}, 0);
      $display("test reset done");
      go;
      repeat (5) @(posedge clk_i);
      check("status start", cal_status[0][STAT_DBI_DESKEW_BIT], 1);
      wait_for(1'b0, 5000);
      check("writes", wr_cnt, 2 * LANES);
      check("reads", rd_cnt, 2 * LANES * N);
      check("error", cal_error, 0);
      check("status done", cal_status[0][STAT_DBI_DONE_BIT], 1);
      $display("test pass done");
      lane = $urandom_range(0, 7);
      bitn = $urandom_range(0, 7);
      flip = 64'h1 << (lane * 8 + bitn);
      do_reset;
      go;
      wait_for(1'b1, 5000);
      check("writes before error", wr_cnt, 2 * lane + 1);
      check("code", err_code, ERR_MISMATCH);
      check("nibble", err_nib, lane * 2 + bitn / 4);
      w0 = wr_cnt;
      r0 = rd_cnt;
      repeat (300) @(posedge clk_i);
      #1 check("loop writes", wr_cnt - w0, 0);
      check("loop reads", rd_cnt - r0 >= 20, 1);
      check("held bit", {cal_error, err_code, err_bit}, {1'b1, ERR_MISMATCH, 8'(lane * 8 + bitn)});
      $display("test mismatch done");
      flip = '0;
      mute = 1'b1;
      do_reset;
      go;
      wait_for(1'b1, 500);
      check("timeout code", err_code, ERR_TIMEOUT);
      $display("test timeout done");
      stop_test;
   end
endmodule : dbi_deskew_stage_tb
